// File: hw/acs_top.sv
// conversion start control and serial result output of a 14-bit converter
// assumes: all pin inputs synchronous to clock_in; pads resolve the enables
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"
module acs_top #(
	parameter int BIT_DIV = `ACS_BIT_DIV
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire logic sel_n_in,
	input wire logic sample_start_n_in,
	input wire logic mode_in,
	input wire logic frame_polarity_sel_in,
	input wire logic comparator_in,
	output acs_pkg::acs_pins_type pins_out,
	output acs_pkg::acs_pins_type pins_oe_out,
	output logic hold_out,
	output logic [13:0] dac_code_out
);
	import acs_pkg::*;
	localparam int DW = (BIT_DIV > 2) ? $clog2(BIT_DIV) : 1;
	localparam logic [DW-1:0] DIV_LAST = DW'(BIT_DIV - 1);
	localparam logic [DW-1:0] DIV_HALF = DW'(BIT_DIV / 2);

	initial begin
		if (BIT_DIV < 2 || (BIT_DIV % 2) != 0)
			$error("acs_top needs an even BIT_DIV of two or more");
	end

	acs_state_type state_r, state_nxt;
	acs_pins_type pins_r, pins_nxt, oe_r, oe_nxt;
	acs_ctrl_type ctrl;
	acs_stat_type stat;
	logic [DW-1:0] div_r, div_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [15:0] count_r, count_nxt;
	logic [13:0] result;
	logic tick, start_lvl, start_edge, cont_go, sar_load, sar_step;
	logic prev_r, prev_nxt, hold_r, hold_nxt, cont_r, cont_nxt;
	logic frame_r, frame_nxt, pwr_seen_r, pwr_low_r;

	// shift clock divider: the data step sits on its rising edge
	assign tick = ce_in && (div_r == '0);

	always_comb begin
		div_nxt = (div_r == DIV_LAST) ? '0 : div_r + DW'(1);
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in)
			div_r <= '0;
		else if (ce_in)
			div_r <= div_nxt;
	end

	// mode level is caught once, after reset release
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			pwr_seen_r <= 1'b0;
			pwr_low_r <= 1'b0;
		end else if (ce_in && !pwr_seen_r) begin
			pwr_seen_r <= 1'b1;
			pwr_low_r <= !mode_in;
		end
	end

	assign start_lvl = !sel_n_in && !sample_start_n_in && ctrl.enable;
	// one edge detector serves both start inputs
	assign start_edge = start_lvl && !prev_r;
	// a mode pin that was high at power-up never allows free running
	assign cont_go = start_lvl && !mode_in && pwr_low_r;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		count_nxt = count_r;
		prev_nxt = prev_r;
		hold_nxt = hold_r;
		cont_nxt = cont_r;
		frame_nxt = frame_r;
		pins_nxt = pins_r;
		sar_load = 1'b0;
		sar_step = 1'b0;
		if (ce_in)
			pins_nxt.shift_clk = (div_nxt != '0) && (div_nxt <= DIV_HALF);
		if (tick) begin
			// state moves on the shift clock's rising edge; only the deselect abort below moves it between ticks
			prev_nxt = start_lvl;
			pins_nxt.frame_lead_pulse = 1'b0;
			pins_nxt.serial_result = 1'b0;
			case (state_r)
			ACS_ST_INIT: begin
				hold_nxt = 1'b1;
				cnt_nxt = cnt_r + 5'h01;
				if (cnt_r == `ACS_POWERUP_LAST) begin
					state_nxt = ACS_ST_TRACK;
					hold_nxt = 1'b0;
					cnt_nxt = 5'h00;
				end
			end
			ACS_ST_TRACK: begin
				if (cont_go || start_edge) begin
					state_nxt = ACS_ST_LEAD;
					cont_nxt = cont_go;
					hold_nxt = !cont_go;
					sar_load = 1'b1;
					pins_nxt.frame_lead_pulse = 1'b1;
				end
			end
			ACS_ST_LEAD: begin
				// msb goes out as the lead pulse falls
				state_nxt = ACS_ST_DATA;
				cnt_nxt = 5'h00;
				hold_nxt = 1'b1;
				frame_nxt = !cont_r;
				sar_step = 1'b1;
				pins_nxt.serial_result = !comparator_in;
			end
			ACS_ST_DATA: begin
				if (cnt_r == `ACS_DATA_LAST) begin
					hold_nxt = 1'b0;
					count_nxt = count_r + 16'h0001;
					cnt_nxt = 5'h00;
					state_nxt = cont_r ? ACS_ST_TRACK : ACS_ST_TAIL;
					frame_nxt = !cont_r;
				end else begin
					cnt_nxt = cnt_r + 5'h01;
					sar_step = 1'b1;
					pins_nxt.serial_result = comparator_in;
				end
			end
			ACS_ST_TAIL: begin
				// two trailing zeros keep the frame open; starts ignored
				cnt_nxt = cnt_r + 5'h01;
				if (cnt_r == `ACS_TAIL_LAST) begin
					state_nxt = ACS_ST_TRACK;
					frame_nxt = 1'b0;
					cnt_nxt = 5'h00;
				end
			end
			default: begin
				state_nxt = ACS_ST_INIT;
				cnt_nxt = 5'h00;
			end
			endcase
		end
		// deselect aborts at once, even between ticks; power-up count goes on
		if (ce_in && sel_n_in && state_r != ACS_ST_INIT) begin
			state_nxt = ACS_ST_TRACK;
			hold_nxt = 1'b0;
			frame_nxt = 1'b0;
			cnt_nxt = 5'h00;
			prev_nxt = 1'b0;
			pins_nxt.serial_result = 1'b0;
			pins_nxt.frame_lead_pulse = 1'b0;
		end
		pins_nxt.frame_low_output = frame_nxt ^ frame_polarity_sel_in;
		oe_nxt = ce_in ? {4{!sel_n_in}} : oe_r;
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state_r <= ACS_ST_INIT;
			cnt_r <= 5'h00;
			count_r <= 16'h0000;
			prev_r <= 1'b0;
			hold_r <= 1'b1;
			cont_r <= 1'b0;
			frame_r <= 1'b0;
			pins_r <= '0;
			oe_r <= '0;
		end else if (ce_in) begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			count_r <= count_nxt;
			prev_r <= prev_nxt;
			hold_r <= hold_nxt;
			cont_r <= cont_nxt;
			frame_r <= frame_nxt;
			pins_r <= pins_nxt;
			oe_r <= oe_nxt;
		end
	end

	acs_sar #(
		.BITS(`ACS_DATA_BITS)
	) u_sar (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.load_in(sar_load),
		.step_in(sar_step),
		.comparator_in(comparator_in),
		.code_out(dac_code_out),
		.result_out(result)
	);

	always_comb begin
		stat.busy = (state_r == ACS_ST_LEAD) || (state_r == ACS_ST_DATA) ||
			(state_r == ACS_ST_TAIL);
		stat.hold = hold_r;
		stat.init_done = (state_r != ACS_ST_INIT);
		stat.cont_ok = pwr_low_r;
		stat.result = {!result[13], result[12:0]};
		stat.count = count_r;
	end

	acs_ahb u_ahb (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.hsel_in(hsel_in),
		.haddr_in(haddr_in),
		.htrans_in(htrans_in),
		.hwrite_in(hwrite_in),
		.hsize_in(hsize_in),
		.hwdata_in(hwdata_in),
		.hready_in(hready_in),
		.stat_in(stat),
		.hrdata_out(hrdata_out),
		.hreadyout_out(hreadyout_out),
		.hresp_out(hresp_out),
		.ctrl_out(ctrl)
	);

	assign pins_out = pins_r;
	assign pins_oe_out = oe_r;
	assign hold_out = hold_r;

	// checking helpers: ticks inside a frame, ticks between lead pulses
	logic [4:0] h_frame_r, h_gap_r;
	logic h_chain_r;
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			h_frame_r <= 5'h00;
			h_gap_r <= 5'h00;
			h_chain_r <= 1'b0;
		end else if (tick) begin
			h_frame_r <= frame_r ? h_frame_r + 5'h01 : 5'h00;
			h_gap_r <= (state_r == ACS_ST_LEAD) ? 5'h00 :
				((h_gap_r == 5'h1F) ? h_gap_r : h_gap_r + 5'h01);
			if (state_r == ACS_ST_DATA && cnt_r == `ACS_DATA_LAST)
				h_chain_r <= cont_r && !sel_n_in;
			else if (sel_n_in || (state_r == ACS_ST_TRACK && !cont_go))
				h_chain_r <= 1'b0;
		end
	end

	deselect_float_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		(ce_in && sel_n_in) |=> (pins_oe_out == '0) && !pins_out.frame_lead_pulse)
		else $error("outputs driven while deselected");

	start_needs_sel_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		$rose(pins_out.frame_lead_pulse) |->
		!$past(sel_n_in) && !$past(sample_start_n_in) && $past(ctrl.enable))
		else $error("conversion started without select");

	lead_before_msb_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		($fell(pins_out.frame_lead_pulse) && !$past(sel_n_in)) |->
		state_r == ACS_ST_DATA && cnt_r == 5'h00 && hold_out)
		else $error("lead pulse not followed by the msb");

	frame_length_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		($fell(frame_r) && !$past(sel_n_in)) |-> h_frame_r == `ACS_FRAME_TICKS)
		else $error("frame not sixteen cycles long");

	cont_frame_still_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		(cont_r && state_r == ACS_ST_DATA) |-> !frame_r)
		else $error("frame moved in continuous mode");

	cont_period_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		(tick && state_r == ACS_ST_LEAD && h_chain_r) |-> h_gap_r == `ACS_CONT_GAP)
		else $error("continuous conversions not sixteen cycles apart");

	track_after_last_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		($fell(hold_out) && !$past(sel_n_in) && $past(state_r) != ACS_ST_INIT) |->
		$past(state_r) == ACS_ST_DATA && $past(cnt_r) == `ACS_DATA_LAST)
		else $error("tracking resumed at the wrong bit");

	busy_ignores_start_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		(tick && (state_r == ACS_ST_DATA || state_r == ACS_ST_TAIL)) |=>
		state_r != ACS_ST_LEAD)
		else $error("conversion restarted while busy");

	data_on_rise_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		($changed(pins_out.serial_result) && !$past(sel_n_in)) |->
		$rose(pins_out.shift_clk))
		else $error("serial data moved off the rising shift clock");

	tail_zero_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		(state_r == ACS_ST_TAIL) |-> !pins_out.serial_result)
		else $error("trailing bit not zero");

	cover_single_c: cover property (@(posedge clock_in) disable iff (rst_in)
		state_r == ACS_ST_TAIL ##1 state_r == ACS_ST_TRACK);
	cover_cont_c: cover property (@(posedge clock_in) disable iff (rst_in)
		tick && state_r == ACS_ST_LEAD && h_chain_r);
	cover_abort_c: cover property (@(posedge clock_in) disable iff (rst_in)
		state_r == ACS_ST_DATA ##1 (sel_n_in && state_r == ACS_ST_TRACK));
endmodule : acs_top
`default_nettype wire

// File: hw/acs_map.svh
// offsets, field positions, reset values and tick counts of the converter
// assumes: included by bare name from the design modules and the bench
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

`define ACS_OFS_CTRL 8'h00
`define ACS_OFS_STATUS 8'h04
`define ACS_OFS_RESULT 8'h08
`define ACS_OFS_COUNT 8'h0C
`define ACS_CTRL_RESET 32'h0000_0001
`define ACS_CTRL_EN_BIT 0
`define ACS_STAT_BUSY_BIT 0
`define ACS_STAT_HOLD_BIT 1
`define ACS_STAT_INIT_BIT 2
`define ACS_STAT_CONT_BIT 3
`define ACS_HSIZE_WORD 3'h2
`define ACS_DATA_BITS 14
`define ACS_BIT_DIV 2
`define ACS_POWERUP_LAST 5'h0F
`define ACS_DATA_LAST 5'h0D
`define ACS_TAIL_LAST 5'h01
`define ACS_FRAME_TICKS 5'h10
`define ACS_CONT_GAP 5'h0F

`endif

// File: hw/acs_pkg.sv
// types shared by the converter control modules
// assumes: acs_map.svh is on the include path
package acs_pkg;
	typedef enum logic [4:0] {
		ACS_ST_INIT = 5'h01,
		ACS_ST_TRACK = 5'h02,
		ACS_ST_LEAD = 5'h04,
		ACS_ST_DATA = 5'h08,
		ACS_ST_TAIL = 5'h10
	} acs_state_type;

	typedef struct packed {
		logic shift_clk;
		logic serial_result;
		logic frame_low_output;
		logic frame_lead_pulse;
	} acs_pins_type;

	typedef struct packed {
		logic enable;
	} acs_ctrl_type;

	typedef struct packed {
		logic busy;
		logic hold;
		logic init_done;
		logic cont_ok;
		logic [13:0] result;
		logic [15:0] count;
	} acs_stat_type;
endpackage : acs_pkg

// File: hw/acs_sar.sv
// successive-approximation register: one trial bit decided per step
// assumes: comparator_in is high when the held input is at or above the trial
`timescale 1ns/1ps
`default_nettype none
module acs_sar #(
	parameter int BITS = 14
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic load_in,
	input wire logic step_in,
	input wire logic comparator_in,
	output logic [BITS-1:0] code_out,
	output logic [BITS-1:0] result_out
);
	logic [BITS-1:0] trial_r, trial_nxt, mask_r, mask_nxt;
	logic [BITS-1:0] result_r, result_nxt, trial_step;

	initial begin
		if (BITS < 2)
			$error("acs_sar needs at least two bits");
	end

	// keep the decided bit, raise the next trial bit
	for (genvar i = 0; i < BITS; i++) begin : g_bit
		if (i == BITS - 1) begin : g_top
			assign trial_step[i] = mask_r[i] ? comparator_in : trial_r[i];
		end else begin : g_low
			assign trial_step[i] = mask_r[i] ? comparator_in :
				(trial_r[i] | mask_r[i+1]);
		end
	end

	always_comb begin
		trial_nxt = trial_r;
		mask_nxt = mask_r;
		result_nxt = result_r;
		if (load_in) begin
			mask_nxt = {1'b1, {(BITS-1){1'b0}}};
			trial_nxt = mask_nxt;
		end else if (step_in && (mask_r != '0)) begin
			trial_nxt = trial_step;
			mask_nxt = mask_r >> 1;
			if (mask_r[0])
				result_nxt = trial_step;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			trial_r <= '0;
			mask_r <= '0;
			result_r <= '0;
		end else if (ce_in) begin
			trial_r <= trial_nxt;
			mask_r <= mask_nxt;
			result_r <= result_nxt;
		end
	end

	assign code_out = trial_r;
	assign result_out = result_r;
endmodule : acs_sar
`default_nettype wire

// File: hw/acs_ahb.sv
// ahb-lite slave holding the control word and showing converter status
// assumes: single word transfers, zero wait states, bus idle while ce is low
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"
module acs_ahb (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	input wire acs_pkg::acs_stat_type stat_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	output acs_pkg::acs_ctrl_type ctrl_out
);
	import acs_pkg::*;
	logic take, wr_r, wr_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic [31:0] rdata_r, rdata_nxt, ctrl_r, ctrl_nxt;

	assign take = hsel_in && htrans_in[1] && hready_in;

	always_comb begin
		wr_nxt = take && hwrite_in && (hsize_in == `ACS_HSIZE_WORD);
		addr_nxt = take ? haddr_in[7:0] : addr_r;
		ctrl_nxt = ctrl_r;
		if (wr_r && addr_r == `ACS_OFS_CTRL)
			ctrl_nxt = {31'h0000_0000, hwdata_in[`ACS_CTRL_EN_BIT]};
		rdata_nxt = rdata_r;
		if (take && !hwrite_in) begin
			// unmapped words read as zero
			rdata_nxt = 32'h0000_0000;
			if (haddr_in[31:8] == 24'h00_0000) begin
				case (haddr_in[7:0])
				`ACS_OFS_CTRL: rdata_nxt = ctrl_r;
				`ACS_OFS_STATUS: rdata_nxt = {28'h000_0000, stat_in.cont_ok,
					stat_in.init_done, stat_in.hold, stat_in.busy};
				`ACS_OFS_RESULT: rdata_nxt = {18'h0_0000, stat_in.result};
				`ACS_OFS_COUNT: rdata_nxt = {16'h0000, stat_in.count};
				default: rdata_nxt = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			wr_r <= 1'b0;
			addr_r <= 8'h00;
			ctrl_r <= `ACS_CTRL_RESET;
			rdata_r <= 32'h0000_0000;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else if (ce_in) begin
			wr_r <= wr_nxt;
			addr_r <= addr_nxt;
			ctrl_r <= ctrl_nxt;
			rdata_r <= rdata_nxt;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end
	end

	assign hrdata_out = rdata_r;
	assign ctrl_out.enable = ctrl_r[`ACS_CTRL_EN_BIT];
endmodule : acs_ahb
`default_nettype wire

// File: testbench/acs_host_model.sv
// host serial port model: takes every 16-bit result off the serial wire
// assumes: one clock domain; released lines are resolved here from enables
`timescale 1ns/1ps
`default_nettype none
module acs_host_model (
	input wire logic clock_in,
	input wire acs_pkg::acs_pins_type pins_in,
	input wire acs_pkg::acs_pins_type pins_oe_in,
	output logic [15:0] word_out,
	output logic [15:0] frame_out,
	output logic [15:0] count_out
);
	import acs_pkg::*;
	acs_pins_type last_r = '0;
	acs_pins_type line_w;
	logic [15:0] off_r = '0;
	logic [15:0] off_seen = '0;
	logic [15:0] w_r = '0;
	logic [15:0] f_r = '0;
	logic [4:0] left_r = '0;
	logic lead_r = 1'b0;
	initial begin
		word_out = '0;
		frame_out = '0;
		count_out = '0;
	end
	// a released line shows the inverse of its last level, never a copy
	always @(posedge clock_in) begin
		for (int i = 0; i < 4; i++) if (pins_oe_in[i]) last_r[i] <= pins_in[i];
		if (!pins_oe_in.shift_clk) off_r <= off_r + 16'h0001;
	end
	always_comb begin
		for (int i = 0; i < 4; i++) line_w[i] = pins_oe_in[i] ? pins_in[i] : ~last_r[i];
	end
	// bits are taken on the shift clock fall, half a bit after they change
	always @(negedge line_w.shift_clk) begin
		if (off_r != off_seen || !pins_oe_in.shift_clk) begin
			// a fall on a released line is no bit and no lead
			left_r = 5'h00;
			off_seen = off_r;
			lead_r = pins_oe_in.shift_clk && line_w.frame_lead_pulse;
		end else begin
			if (left_r == 5'h00 && lead_r) left_r = 5'h10;
			if (left_r != 5'h00) begin
				w_r = {w_r[14:0], line_w.serial_result};
				f_r = {f_r[14:0], line_w.frame_low_output};
				left_r = left_r - 5'h01;
				if (left_r == 5'h00) begin
					word_out <= w_r;
					frame_out <= f_r;
					count_out <= count_out + 16'h0001;
				end
			end
			lead_r = line_w.frame_lead_pulse;
		end
	end
endmodule : acs_host_model
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench of the converter control block
// assumes: an ideal comparator modelled here; host model on the serial side
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"
module tb;
	import acs_pkg::*;
	// one bit per two clocks stands in for the slow host clock
	localparam int DIV = 2;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [1:0] htrans = '0;
	logic sel_n = 1'b1;
	logic start_n = 1'b1;
	logic mode = 1'b1;
	logic pol = 1'b1;
	logic cmp = 1'b0;
	logic [13:0] analog = '0;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	logic hold;
	logic [13:0] dac;
	acs_pins_type pins;
	acs_pins_type oe;
	logic [15:0] word;
	logic [15:0] frame;
	logic [15:0] wcnt;
	logic [15:0] expq[$];
	logic cont_on = 1'b0;
	logic [15:0] cont_w = '0;
	logic [13:0] edge_tbl [4] = '{14'h0000, 14'h3FFF, 14'h2000, 14'h1FFF};
	int fails = 0;
	int checked = 0;
	int cyc = 0;
	int nw = 0;
	always #4 clock_in = ~clock_in;
	acs_top #(.BIT_DIV(DIV)) acs_top_inst (.clock_in(clock_in),
		.rst_in(rst_in), .ce_in(1'b1), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
		.hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
		.hreadyout_out(hready), .hresp_out(hresp), .sel_n_in(sel_n),
		.sample_start_n_in(start_n), .mode_in(mode),
		.frame_polarity_sel_in(pol), .comparator_in(cmp), .pins_out(pins),
		.pins_oe_out(oe), .hold_out(hold), .dac_code_out(dac));
	acs_host_model acs_host_model_inst (.clock_in(clock_in), .pins_in(pins),
		.pins_oe_in(oe), .word_out(word), .frame_out(frame),
		.count_out(wcnt));
	// comparator lags the trial code by one clock, well inside a bit time
	always @(posedge clock_in) cmp <= (analog >= dac);
	task results;
		$display("fails=%0d checked=%0d", fails, checked);
		if (fails == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results
	task chk_val(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk_val
	task chk_word(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t word got %h exp %h", $time, got, exp);
		end
	endtask : chk_word
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 6000) begin
			fails++;
			$display("CHECK FAILED %0t timeout", $time);
			results();
		end
	end
	always @(wcnt) begin
		if (wcnt !== 16'h0000) begin
			if (cont_on) begin
				chk_word(word, cont_w);
				chk_val(frame == 16'h0000 || frame == 16'hFFFF, 1, "frame");
			end else if (expq.size() == 0) begin
				fails++;
				$display("CHECK FAILED %0t unexpected word", $time);
			end else begin
				chk_word(word, expq.pop_front());
				chk_val(frame, pol ? 32'h0 : 32'hFFFF, "frame");
			end
		end
	end
	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clock_in); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clock_in); while (hready !== 1'b1);
		rd = hrdata;
		chk_val(hresp, 0, "okay response");
	endtask : ahb
	task wait_word;
		logic [15:0] n;
		n = wcnt;
		for (int k = 0; k < 200 && wcnt === n; k++) @(posedge clock_in);
	endtask : wait_word
	task convert(input logic by_sel, input logic [13:0] v);
		logic [15:0] n;
		analog <= v;
		@(posedge clock_in);
		expq.push_back({~v[13], v[12:0], 2'b00});
		nw++;
		n = wcnt;
		if (by_sel) sel_n <= 1'b0; else start_n <= 1'b0;
		for (int k = 0; k < 100 && wcnt === n; k++) begin
			@(posedge clock_in);
			if (k == 10) chk_val(hold, 1, "hold in conversion");
			// a second start edge in mid-conversion must leave no trace
			if (k == 20 && !by_sel) start_n <= 1'b1;
			if (k == 24 && !by_sel) start_n <= 1'b0;
		end
		chk_val(hold, 0, "track after last bit");
		if (by_sel) sel_n <= 1'b1; else start_n <= 1'b1;
		repeat (60) @(posedge clock_in);
	endtask : convert
	initial begin
		logic [31:0] rd;
		logic [15:0] n;
		time t0;
		void'($urandom(57));
		repeat (10) @(posedge clock_in);
		rst_in <= 1'b0;
		chk_val(oe, 0, "released while deselected");
		repeat (40) @(posedge clock_in);
		ahb(1'b0, `ACS_OFS_CTRL, 0, rd);
		chk_val(rd, `ACS_CTRL_RESET, "ctrl reset");
		ahb(1'b0, 32'h0000_0010, 0, rd);
		chk_val(rd, 0, "unmapped read");
		sel_n <= 1'b0;
		repeat (4) @(posedge clock_in);
		chk_val(oe, 32'hF, "driven while selected");
		for (int i = 0; i < 6; i++) begin
			pol <= i[0];
			convert(1'b0, i < 4 ? edge_tbl[i] : 14'($urandom));
		end
		start_n <= 1'b0;
		sel_n <= 1'b1;
		repeat (4) @(posedge clock_in);
		chk_val(oe, 0, "floated by select");
		convert(1'b1, 14'($urandom));
		convert(1'b1, 14'($urandom));
		ahb(1'b0, `ACS_OFS_COUNT, 0, rd);
		chk_val(rd, nw, "conversion count");
		sel_n <= 1'b0;
		repeat (20) @(posedge clock_in);
		sel_n <= 1'b1;
		repeat (3) @(posedge clock_in);
		chk_val({hold, oe}, 0, "abort floats and tracks");
		repeat (60) @(posedge clock_in);
		for (int i = 0; i < 2; i++) begin
			start_n <= 1'b1;
			ahb(1'b1, `ACS_OFS_CTRL, i, rd);
			sel_n <= i[0];
			repeat (4) @(posedge clock_in);
			n = wcnt;
			start_n <= 1'b0;
			repeat (60) @(posedge clock_in);
			chk_val(wcnt, n, "start refused");
		end
		start_n <= 1'b1;
		mode <= 1'b0;
		analog <= 14'($urandom);
		rst_in <= 1'b1;
		repeat (10) @(posedge clock_in);
		cont_w <= {~analog[13], analog[12:0], 2'b00};
		cont_on <= 1'b1;
		start_n <= 1'b0;
		sel_n <= 1'b0;
		rst_in <= 1'b0;
		wait_word();
		wait_word();
		t0 = $time;
		wait_word();
		chk_val(32'($time - t0), 16 * DIV * 8, "conversion period");
		start_n <= 1'b1;
		repeat (80) @(posedge clock_in);
		n = wcnt;
		repeat (100) @(posedge clock_in);
		chk_val(wcnt, n, "stopped");
		sel_n <= 1'b1;
		repeat (3) @(posedge clock_in);
		chk_val(oe, 0, "floated in continuous");
		results();
	end
endmodule : tb
`default_nettype wire
